//--- verilog/tap_regs.svh
// constants for the test access port block
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH
`define IR_WIDTH       4
`define IR_RESET_VAL   4'h1
`define IR_CAPTURE_VAL 4'h1
`define IR_BYPASS_VAL  4'hf
`define LBUS_RST_CYC   8'h10
`define LBUS_RST_WIDTH 8
`endif

//--- verilog/tap_pkg.sv
// types shared by the test access port block
package tap_pkg;
   // gray codes along the shift-dr path
   typedef enum logic [3:0] {
      st_reset      = 4'h0,
      st_idle       = 4'h1,
      st_sel_dr     = 4'h3,
      st_cap_dr     = 4'h2,
      st_shift_dr   = 4'h6,
      st_exit1_dr   = 4'h7,
      st_pause_dr   = 4'h5,
      st_exit2_dr   = 4'h4,
      st_update_dr  = 4'hc,
      st_sel_ir     = 4'hd,
      st_cap_ir     = 4'hf,
      st_shift_ir   = 4'he,
      st_exit1_ir   = 4'ha,
      st_pause_ir   = 4'hb,
      st_exit2_ir   = 4'h9,
      st_update_ir  = 4'h8
   } tap_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } link_in_t;

   typedef struct packed {
      logic tdo;
      logic tdo_oe_n;
   } link_out_t;
endpackage

//--- verilog/tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/1ns
`default_nettype none
module tap_fsm (
   input  wire logic            clk,
   input  wire logic            reset,
   input  wire logic            trst_n,
   input  wire logic            step,
   input  wire logic            tms,
   output tap_pkg::tap_state_t  state
);
   typedef struct packed {
      tap_pkg::tap_state_t st;
   } fsm_t;
   fsm_t s_r, s_nxt;

   // next state from mode select, only on rising link clock
   always_comb begin
      s_nxt = s_r;
      if (step) begin
         case (s_r.st)
            tap_pkg::st_reset:     s_nxt.st = tms ? tap_pkg::st_reset : tap_pkg::st_idle;
            tap_pkg::st_idle:      s_nxt.st = tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
            tap_pkg::st_sel_dr:    s_nxt.st = tms ? tap_pkg::st_sel_ir : tap_pkg::st_cap_dr;
            tap_pkg::st_cap_dr:    s_nxt.st = tms ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
            tap_pkg::st_shift_dr:  s_nxt.st = tms ? tap_pkg::st_exit1_dr : tap_pkg::st_shift_dr;
            tap_pkg::st_exit1_dr:  s_nxt.st = tms ? tap_pkg::st_update_dr : tap_pkg::st_pause_dr;
            tap_pkg::st_pause_dr:  s_nxt.st = tms ? tap_pkg::st_exit2_dr : tap_pkg::st_pause_dr;
            tap_pkg::st_exit2_dr:  s_nxt.st = tms ? tap_pkg::st_update_dr : tap_pkg::st_shift_dr;
            tap_pkg::st_update_dr: s_nxt.st = tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
            tap_pkg::st_sel_ir:    s_nxt.st = tms ? tap_pkg::st_reset : tap_pkg::st_cap_ir;
            tap_pkg::st_cap_ir:    s_nxt.st = tms ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
            tap_pkg::st_shift_ir:  s_nxt.st = tms ? tap_pkg::st_exit1_ir : tap_pkg::st_shift_ir;
            tap_pkg::st_exit1_ir:  s_nxt.st = tms ? tap_pkg::st_update_ir : tap_pkg::st_pause_ir;
            tap_pkg::st_pause_ir:  s_nxt.st = tms ? tap_pkg::st_exit2_ir : tap_pkg::st_pause_ir;
            tap_pkg::st_exit2_ir:  s_nxt.st = tms ? tap_pkg::st_update_ir : tap_pkg::st_shift_ir;
            tap_pkg::st_update_ir: s_nxt.st = tms ? tap_pkg::st_sel_dr : tap_pkg::st_idle;
            default:               s_nxt.st = tap_pkg::st_reset;
         endcase
      end
   end

   // test reset clears the controller without waiting for any edge
   always_ff @(posedge clk or negedge trst_n) begin
      if (!trst_n) begin
         s_r.st <= tap_pkg::st_reset;
      end else if (reset) begin
         s_r.st <= tap_pkg::st_reset;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign state = s_r.st;
endmodule
`default_nettype wire

//--- verilog/tap_port.sv
// boundary-scan test access port: link sampling, shift paths, serial output
//
// What this block does
// - mode select sampled each rising test clock
// - data input captured rising edge while shifting
// - data output driven falling edge while shifting
// - data output floats outside shift states
// - test reset clears controller immediately
// - undriven data and mode inputs read high
// - local bus reset output informs bus devices
//
// how it hangs together
// - link pins pass the pull-up mux and two flops before any other logic
// - the link clock is only sampled, never used as a clock
// - edge detect compares stage two with its own delay
// - a rise steps the controller and the shift paths
// - a fall only updates the serial output pair
// - the output pair changes about three clocks after a fall
//
// limits
// - tck phases under one clock can go unseen
// - tck should stay well below clk
// - only the one-bit bypass data path exists
// - instruction value is held, not decoded here
// - capture and reset values of the instruction are arbitrary
// - tdo is forced low while released
//
// reset
// - system reset clears most registers here; ir, tdo_oe_n, lrst_cnt, dinit1, dinit2 load set values
// - test reset reaches only the controller, at once
// - the instruction reloads on the next rise in reset state
// - serial output floats after system reset
//
// local bus reset
// - held low through system reset
// - stretched for a fixed count after each request
// - a new request restarts the count
//
// pull-up model
// - a low driven flag means the pins float
// - floating mode select and data read as one
// - five rises with floating pins reach reset
//
// debugger init
// - a static level, synchronised only
// - no edge of it starts anything
// - reads inactive through reset, pin high
//
// timing walk, shift-dr
// - rise in capture clears bypass
// - first fall in shift drives bypass out
// - each rise takes tdi into bypass
// - next fall shows that bit on tdo
// - rise with mode select high leaves shift
// - next fall releases tdo
//
// trade-offs
// - sampling costs latency but avoids a second clock domain
// - state output is one clock late to stay registered
// - one struct of state keeps reset and next value together
`timescale 1ns/1ns
`default_nettype none
`include "tap_regs.svh"
module tap_port #(
   parameter int IR_W = `IR_WIDTH
) (
   input  wire logic                clk,
   input  wire logic                reset,
   input  wire tap_pkg::link_in_t   link_in,
   input  wire logic                link_in_driven,
   input  wire logic                trst_n,
   input  wire logic                debugger_init_in_n,
   input  wire logic                lbus_reset_req,
   output tap_pkg::link_out_t       link_out,
   output logic                     lbus_reset_out_n,
   output logic                     debug_init_active,
   output logic [IR_W-1:0]          instr_out,
   output tap_pkg::tap_state_t      tap_state_out
);
   typedef struct packed {
      tap_pkg::link_in_t   s1;
      tap_pkg::link_in_t   s2;
      logic                tck_d;
      logic                dinit1;
      logic                dinit2;
      logic [IR_W-1:0]     ir_sh;
      logic [IR_W-1:0]     ir;
      logic                byp;
      logic                tdo;
      logic                tdo_oe_n;
      logic [`LBUS_RST_WIDTH-1:0] lrst_cnt;
      logic                lrst_n;
      tap_pkg::tap_state_t st_q;
   } port_t;

   port_t               r_r, r_nxt;
   tap_pkg::tap_state_t state;
   tap_pkg::link_in_t   pin;
   logic                rise;
   logic                fall;

   // undriven pins fall to the internal pull-up level
   always_comb begin
      pin = link_in;
      if (!link_in_driven) begin
         pin.tms = 1'b1;
         pin.tdi = 1'b1;
      end
   end

   // edges of the sampled link clock; stage one is never looked at
   assign rise = r_r.s2.tck & ~r_r.tck_d;
   assign fall = ~r_r.s2.tck & r_r.tck_d;

   // controller steps on detected rises only
   tap_fsm u_fsm (
      .clk    (clk),
      .reset  (reset),
      .trst_n (trst_n),
      .step   (rise),
      .tms    (r_r.s2.tms),
      .state  (state)
   );

   // true in either shift state
   function automatic logic is_shift(input tap_pkg::tap_state_t s);
      is_shift = (s == tap_pkg::st_shift_dr) || (s == tap_pkg::st_shift_ir);
   endfunction

   always_comb begin
      r_nxt       = r_r;
      r_nxt.s1    = pin;
      r_nxt.s2    = r_r.s1;
      r_nxt.tck_d = r_r.s2.tck;
      // static level, only synchronised, never edge-detected
      r_nxt.dinit1 = debugger_init_in_n;
      r_nxt.dinit2 = r_r.dinit1;
      r_nxt.st_q   = state;

      // actions belong to the state the rise leaves
      if (rise) begin
         case (state)
            // reset state reloads the instruction
            tap_pkg::st_reset: begin
               r_nxt.ir = IR_W'(`IR_RESET_VAL);
            end
            // fixed pattern goes into the shifter
            tap_pkg::st_cap_ir: begin
               r_nxt.ir_sh = IR_W'(`IR_CAPTURE_VAL);
            end
            // bypass always captures zero
            tap_pkg::st_cap_dr: begin
               r_nxt.byp = 1'b0;
            end
            // lsb leaves first, tdi enters at the top
            tap_pkg::st_shift_ir: begin
               r_nxt.ir_sh = {r_r.s2.tdi, r_r.ir_sh[IR_W-1:1]};
            end
            // one-bit data path
            tap_pkg::st_shift_dr: begin
               r_nxt.byp = r_r.s2.tdi;
            end
            // shifted value becomes the instruction
            tap_pkg::st_update_ir: begin
               r_nxt.ir = r_r.ir_sh;
            end
            // all other states hold
            default: begin
               r_nxt.byp = r_r.byp;
            end
         endcase
      end

      // output changes only on falling link clock edges
      if (fall) begin
         if (is_shift(state)) begin
            r_nxt.tdo_oe_n = 1'b0;
            r_nxt.tdo = (state == tap_pkg::st_shift_ir) ? r_r.ir_sh[0] : r_r.byp;
         end else begin
            r_nxt.tdo_oe_n = 1'b1;
            r_nxt.tdo      = 1'b0;
         end
      end

      // stretch the local bus reset so slow devices see it
      if (lbus_reset_req) begin
         r_nxt.lrst_cnt = `LBUS_RST_CYC;
         r_nxt.lrst_n   = 1'b0;
      end else if (r_r.lrst_cnt != '0) begin
         r_nxt.lrst_cnt = r_r.lrst_cnt - 1'b1;
         r_nxt.lrst_n   = 1'b0;
      end else begin
         r_nxt.lrst_n = 1'b1;
      end
   end

   // trst only touches the controller; the rest follows system reset
   always_ff @(posedge clk) begin
      if (reset) begin
         r_r          <= '0;
         r_r.ir       <= IR_W'(`IR_RESET_VAL);
         r_r.tdo_oe_n <= 1'b1;
         r_r.lrst_cnt <= `LBUS_RST_CYC;
         r_r.lrst_n   <= 1'b0;
         r_r.dinit1   <= 1'b1;
         r_r.dinit2   <= 1'b1;
      end else begin
         r_r <= r_nxt;
      end
   end

   // every output straight from a register, except debug_init_active, which goes through an inverter
   assign link_out.tdo      = r_r.tdo;
   assign link_out.tdo_oe_n = r_r.tdo_oe_n;
   assign lbus_reset_out_n  = r_r.lrst_n;
   assign debug_init_active = ~r_r.dinit2;
   assign instr_out         = r_r.ir;
   assign tap_state_out     = r_r.st_q;
endmodule
`default_nettype wire

//--- tb/tap_port_assertions.sv
// checker on the test access port pins
`timescale 1ns/1ns
`default_nettype none
module tap_port_chk (
   input wire logic                clk,
   input wire logic                reset,
   input wire tap_pkg::link_in_t   link_in,
   input wire logic                trst_n,
   input wire logic                debugger_init_in_n,
   input wire logic                lbus_reset_req,
   input wire tap_pkg::link_out_t  link_out,
   input wire logic                lbus_reset_out_n,
   input wire logic                debug_init_active,
   input wire tap_pkg::tap_state_t tap_state_out
);
   logic       tck_q_r;
   logic [3:0] quiet_r;
   logic       shf;
   logic       ex1;
   // output may stay on through exit1 until the next fall
   assign shf = tap_state_out inside {tap_pkg::st_shift_dr, tap_pkg::st_shift_ir};
   assign ex1 = tap_state_out inside {tap_pkg::st_exit1_dr, tap_pkg::st_exit1_ir};
   // clk cycles since tck last moved, saturating
   always_ff @(posedge clk) begin
      tck_q_r <= link_in.tck;
      quiet_r <= (reset || link_in.tck != tck_q_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // test reset moves the controller with tck standing, so it is left out
   sequence s_calm; quiet_r > 4'h6 && trst_n && $past(trst_n) && $past(trst_n, 2); endsequence
   sequence s_held; !debugger_init_in_n [*4]; endsequence
   property p_tms_step; s_calm |-> $stable(tap_state_out); endproperty
   a_tms_step: assert property (p_tms_step) else $error("state moved with tck still");
   property p_tdo_fall; s_calm |-> $stable(link_out); endproperty
   a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck still");
   property p_tdo_float; !link_out.tdo_oe_n |-> shf || ex1; endproperty
   a_tdo_float: assert property (p_tdo_float) else $error("tdo driven outside shift");
   property p_shift_on; $changed(tap_state_out) && shf |-> ##[1:16] !link_out.tdo_oe_n; endproperty
   a_shift_on: assert property (p_shift_on) else $error("tdo not driven in shift");
   property p_shift_off; $changed(tap_state_out) && ex1 |-> ##[1:16] link_out.tdo_oe_n; endproperty
   a_shift_off: assert property (p_shift_off) else $error("tdo not released");
   property p_trst; !trst_n |-> ##[1:2] tap_state_out == tap_pkg::st_reset; endproperty
   a_trst: assert property (p_trst) else $error("test reset too slow");
   property p_lbus; lbus_reset_req |-> ##[0:2] !lbus_reset_out_n; endproperty
   a_lbus: assert property (p_lbus) else $error("local bus reset missing");
   property p_dbg; s_held |-> debug_init_active; endproperty
   a_dbg: assert property (p_dbg) else $error("debug init not seen");
endmodule
bind tap_port tap_port_chk i_chk (.clk(clk), .reset(reset), .link_in(link_in), .trst_n(trst_n),
   .debugger_init_in_n(debugger_init_in_n), .lbus_reset_req(lbus_reset_req), .link_out(link_out),
   .lbus_reset_out_n(lbus_reset_out_n), .debug_init_active(debug_init_active), .tap_state_out(tap_state_out));
`default_nettype wire

//--- tb/tap_tester.sv
// tester model on the far side of the serial link
`timescale 1ns/1ns
`default_nettype none
module tap_tester (
   input  wire logic               clk,
   input  wire tap_pkg::link_out_t link_out,
   output var  tap_pkg::link_in_t  link_in,
   output var  logic               link_in_driven
);
   initial begin
      link_in = 3'h3;
      link_in_driven = 1'b1;
   end
   // one tck period of 16 clk; released lines show the inverse so the pull-up must win
   task automatic clock_bit(input logic m, input logic d, input logic drv, output logic o);
      link_in_driven = drv;
      link_in.tms = drv ? m : ~m;
      link_in.tdi = drv ? d : ~d;
      repeat (8) @(negedge clk);
      o = link_out.tdo;
      link_in.tck = 1'b1;
      repeat (8) @(negedge clk);
      link_in.tck = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- tb/tap_port_tb_top.sv
// self-checking bench for the test access port
`timescale 1ns/1ns
`default_nettype none
`include "tap_regs.svh"
module tap_port_tb_top;
   logic                clk, reset, trst_n, init_n, req, drv, lbus_n, act, tdo_seen;
   logic [3:0]          instr;
   tap_pkg::link_in_t   link_in;
   tap_pkg::link_out_t  link_out;
   tap_pkg::tap_state_t state;
   int                  fails, samples_checked;
   tap_port i_dut (.clk(clk), .reset(reset), .link_in(link_in), .link_in_driven(drv), .trst_n(trst_n),
      .debugger_init_in_n(init_n), .lbus_reset_req(req), .link_out(link_out), .lbus_reset_out_n(lbus_n),
      .debug_init_active(act), .instr_out(instr), .tap_state_out(state));
   tap_tester i_tester (.clk(clk), .link_out(link_out), .link_in(link_in), .link_in_driven(drv));
   // compare one value, counting every sample
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   // tms bits taken lsb first, tdi low
   task automatic walk(input logic [7:0] seq, input int n);
      for (int i = 0; i < n; i++) begin
         i_tester.clock_bit(seq[i], 1'b0, 1'b1, tdo_seen);
      end
   endtask
   // capture, shift four bits, update; tdo shows capture, then for dr the bits fed in
   task automatic t_scan(input logic ir, input logic [3:0] pat, input logic [3:0] cap);
      logic [7:0] e;
      e = ir ? {pat, cap} : {3'h0, pat, cap[0]};
      walk(ir ? 8'h03 : 8'h02, 4);
      check("state", state, ir ? tap_pkg::st_shift_ir : tap_pkg::st_shift_dr);
      for (int i = 0; i < 4; i++) begin
         i_tester.clock_bit(i == 3, pat[i], 1'b1, tdo_seen);
         check("tdo", tdo_seen, e[i]);
         check("oe_n", link_out.tdo_oe_n, 1'b0);
      end
      walk(8'h01, 2);
      check("oe_n", link_out.tdo_oe_n, 1'b1);
      check("state", state, tap_pkg::st_idle);
      if (ir) check("instr", instr, pat);
      $display("test scan done");
   endtask
   // floating tms reads high, so five bits reach reset
   task automatic t_float;
      for (int i = 0; i < 5; i++) begin
         i_tester.clock_bit(1'b1, 1'b1, 1'b0, tdo_seen);
      end
      check("state", state, tap_pkg::st_reset);
      $display("test float done");
   endtask
   // test reset in pause-dr with tck standing
   task automatic t_trst;
      walk(8'h0a, 5);
      check("state", state, tap_pkg::st_pause_dr);
      trst_n = 1'b0;
      repeat (2) @(negedge clk);
      check("state", state, tap_pkg::st_reset);
      trst_n = 1'b1;
      $display("test trst done");
   endtask
   // one request pulse stretches the local bus reset
   task automatic t_lbus;
      req = 1'b1;
      @(negedge clk);
      req = 1'b0;
      repeat (2) @(negedge clk);
      check("lbus_n", lbus_n, 1'b0);
      repeat (30) @(negedge clk);
      check("lbus_n", lbus_n, 1'b1);
      $display("test lbus done");
   endtask
   // static debugger init level, on and back off
   task automatic t_dbg;
      init_n = 1'b0;
      repeat (5) @(negedge clk);
      check("dbg", act, 1'b1);
      init_n = 1'b1;
      repeat (5) @(negedge clk);
      check("dbg", act, 1'b0);
      $display("test dbg done");
   endtask
   task automatic final_report;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // watchdog: the run needs well under 200 us
   initial begin
      #200000;
      fails++;
      final_report;
   end
   initial begin
      fails = 0;
      samples_checked = 0;
      reset = 1'b1;
      trst_n = 1'b0;
      init_n = 1'b1;
      req = 1'b0;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      trst_n = 1'b1;
      @(negedge clk);
      check("state", state, tap_pkg::st_reset);
      check("oe_n", link_out.tdo_oe_n, 1'b1);
      check("lbus_n", lbus_n, 1'b0);
      repeat (20) @(negedge clk);
      check("lbus_n", lbus_n, 1'b1);
      t_scan(1'b0, 4'hd, 4'h0);
      t_scan(1'b1, `IR_BYPASS_VAL, `IR_CAPTURE_VAL);
      t_float;
      t_trst;
      t_lbus;
      t_dbg;
      final_report;
   end
endmodule
`default_nettype wire
